//--- hw/acr_pkg.sv
// command codes, acknowledge codes, field positions and state type shared by
// the bus command register block and its current smoothing filter
// assumes a 16-bit command data field and a 4-bit command code / rail select
package acr_pkg;

    localparam int DATA_W = 16;
    localparam int CMD_W = 4;
    localparam int RAIL_W = 4;
    localparam int RW_W = 2;
    localparam int ACK_W = 2;
    localparam int RESP_STAT_W = 5;
    localparam int FILT_SHIFT_W = 4;

    // command codes
    localparam logic [CMD_W-1:0] CMD_RAIL_CURRENT = 4'h2;
    localparam logic [CMD_W-1:0] CMD_STAGE_TEMP = 4'h3;
    localparam logic [CMD_W-1:0] CMD_TARGET_RELOAD = 4'h4;
    localparam logic [CMD_W-1:0] CMD_STATUS = 4'hE;
    localparam logic [CMD_W-1:0] CMD_VERSION = 4'hF;

    // read/write field of the master frame
    localparam logic [RW_W-1:0] RW_WRITE = 2'h0;
    localparam logic [RW_W-1:0] RW_READ = 2'h3;

    localparam logic [RAIL_W-1:0] RAIL_BROADCAST = 4'hF;

    // acknowledge codes
    localparam logic [ACK_W-1:0] ACK_DONE = 2'h0;
    localparam logic [ACK_W-1:0] ACK_NO_ACTION = 2'h1;
    localparam logic [ACK_W-1:0] ACK_BAD_CRC = 2'h2;
    localparam logic [ACK_W-1:0] ACK_INVALID = 2'h3;

    // status word layout
    localparam int STAT_TARGET_BIT = 15;
    localparam int STAT_OVERHEAT_BIT = 12;
    localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;

    // status response field layout
    localparam int RESP_TARGET_BIT = 4;
    localparam int RESP_ALERT_BIT = 3;
    localparam int RESP_CONTROL_BIT = 2;

    // code for compliance with release 1.3 of the bus specification
    localparam logic [DATA_W-1:0] SPEC_VERSION_CODE = 16'h0000;
    localparam logic [DATA_W-1:0] TARGET_RELOAD_DEFAULT = 16'h0000;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } acr_state_type;

endpackage : acr_pkg

//--- hw/acr_current_filter.sv
// first-order smoothing filter for one rail's current samples
// assumes samples arrive on clk with a one-cycle valid strobe; shift 0 passes through
`timescale 1ns/1ps
module acr_current_filter
    import acr_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int FRAC = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // samples and setting
    input wire logic sampleValid,
    input wire logic signed [WIDTH-1:0] sampleIn,
    input wire logic [FILT_SHIFT_W-1:0] smoothShift,
    // filtered value
    output logic signed [WIDTH-1:0] smoothOut
);

    localparam int ACC_W = WIDTH + FRAC + 1;

    if (WIDTH < 2 || FRAC < 1) begin : gBadParam
        $error("acr_current_filter: WIDTH must be >= 2 and FRAC >= 1");
    end

    logic signed [ACC_W-1:0] acc_ff;
    logic signed [ACC_W-1:0] nxt_acc;
    logic signed [ACC_W-1:0] sampleScaled;
    logic signed [ACC_W-1:0] errTerm;
    logic signed [WIDTH-1:0] smoothOut_ff;

    // extra fraction bits keep long time constants from stalling on truncation
    assign sampleScaled = ACC_W'(sampleIn) <<< FRAC;
    assign errTerm = (sampleScaled - acc_ff) >>> smoothShift;
    assign nxt_acc = sampleValid ? acc_ff + errTerm : acc_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_ff <= '0;
            smoothOut_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
            smoothOut_ff <= nxt_acc[FRAC +: WIDTH];
        end
    end

    assign smoothOut = smoothOut_ff;

endmodule : acr_current_filter

//--- hw/acr_command_registers.sv
// command register set behind the adaptive voltage scaling bus slave:
// current and temperature telemetry, target reload, status word, version
// assumes a frame decoder on linkClk delivering checked frames and sending answers
`timescale 1ns/1ps
module acr_command_registers
    import acr_pkg::*;
#(
    parameter int NRAIL = 2,
    parameter int NSENSE = 3,
    parameter logic [DATA_W-1:0] TARGET_TOL = 16'h0000
) (
    // system clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link clock domain
    input wire logic linkClk,
    input wire logic linkRst,
    // decoded master frame, linkClk
    input wire logic frameValid,
    input wire logic [RW_W-1:0] frameRw,
    input wire logic [CMD_W-1:0] frameCmd,
    input wire logic [RAIL_W-1:0] frameRail,
    input wire logic [DATA_W-1:0] frameData,
    input wire logic frameCrcOk,
    // slave answer, linkClk
    output logic linkBusy,
    output logic respValid,
    output logic [ACK_W-1:0] respAck,
    output logic [RESP_STAT_W-1:0] respStatus,
    output logic [DATA_W-1:0] respData,
    // slave data line alert drive
    input wire logic slaveDataLineIn,
    output logic slaveDataLineOut,
    output logic slaveDataLineOe,
    // regulation and monitoring values, clk
    input wire logic busControl,
    input wire logic [NRAIL-1:0] currentSampleValid,
    input wire logic [NRAIL-1:0][DATA_W-1:0] currentSample,
    input wire logic [FILT_SHIFT_W-1:0] smoothShift,
    input wire logic [NRAIL-1:0][DATA_W-1:0] readTemperature1,
    input wire logic [NSENSE-1:0][DATA_W-1:0] sensorTemp,
    input wire logic [NRAIL-1:0][DATA_W-1:0] otWarnLimit,
    input wire logic [NRAIL-1:0][DATA_W-1:0] voutCommand,
    input wire logic [NRAIL-1:0][DATA_W-1:0] voutReading,
    // commanded target per rail
    output logic [NRAIL-1:0][DATA_W-1:0] targetVoltage
);

    localparam int RIDX_W = $clog2(NRAIL);

    if (NRAIL < 2 || NRAIL > 15 || NSENSE < 1) begin : gBadParam
        $error("acr_command_registers: NRAIL must be 2..15 and NSENSE >= 1");
    end

    // link side request capture
    logic reqTgl_ff;
    logic linkBusy_ff;
    logic [RW_W-1:0] lnkRw_ff;
    logic [CMD_W-1:0] lnkCmd_ff;
    logic [RAIL_W-1:0] lnkRail_ff;
    logic lnkCrcOk_ff;
    logic ackSync1_ff;
    logic ackSync2_ff;
    logic ackSeen_ff;
    logic respValid_ff;
    logic [ACK_W-1:0] respAck_ff;
    logic [RESP_STAT_W-1:0] respStatus_ff;
    logic [DATA_W-1:0] respData_ff;
    logic ackTgl_ff;
    logic [ACK_W-1:0] holdAck_ff;
    logic [RESP_STAT_W-1:0] holdStatus_ff;
    logic [DATA_W-1:0] holdData_ff;
    logic frameTake;
    logic ackEdge;

    // frame data is unused: every writable command here ignores its payload
    assign frameTake = frameValid && !linkBusy_ff;
    assign ackEdge = ackSync2_ff ^ ackSeen_ff;

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            reqTgl_ff <= 1'b0;
            lnkRw_ff <= '0;
            lnkCmd_ff <= '0;
            lnkRail_ff <= '0;
            lnkCrcOk_ff <= 1'b0;
        end else if (frameTake) begin
            reqTgl_ff <= ~reqTgl_ff;
            lnkRw_ff <= frameRw;
            lnkCmd_ff <= frameCmd;
            lnkRail_ff <= frameRail;
            lnkCrcOk_ff <= frameCrcOk;
        end
    end

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            ackSync1_ff <= 1'b0;
            ackSync2_ff <= 1'b0;
            ackSeen_ff <= 1'b0;
            linkBusy_ff <= 1'b0;
            respValid_ff <= 1'b0;
        end else begin
            ackSync1_ff <= ackTgl_ff;
            ackSync2_ff <= ackSync1_ff;
            ackSeen_ff <= ackSync2_ff;
            linkBusy_ff <= frameTake || (linkBusy_ff && !ackEdge);
            respValid_ff <= ackEdge;
        end
    end

    // answer words are held stable in clk domain across the toggle handshake
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            respAck_ff <= ACK_DONE;
            respStatus_ff <= '0;
            respData_ff <= '0;
        end else if (ackEdge) begin
            respAck_ff <= holdAck_ff;
            respStatus_ff <= holdStatus_ff;
            respData_ff <= holdData_ff;
        end
    end

    assign linkBusy = linkBusy_ff;
    assign respValid = respValid_ff;
    assign respAck = respAck_ff;
    assign respStatus = respStatus_ff;
    assign respData = respData_ff;

    // clk side request detection
    logic reqSync1_ff;
    logic reqSync2_ff;
    logic reqSeen_ff;
    logic reqEdge;
    acr_state_type state_ff;
    acr_state_type nxt_state;
    logic [RW_W-1:0] cmdRw_ff;
    logic [CMD_W-1:0] cmdCode_ff;
    logic [RAIL_W-1:0] cmdRail_ff;
    logic cmdCrcOk_ff;

    assign reqEdge = reqSync2_ff ^ reqSeen_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reqSync1_ff <= 1'b0;
            reqSync2_ff <= 1'b0;
            reqSeen_ff <= 1'b0;
        end else begin
            reqSync1_ff <= reqTgl_ff;
            reqSync2_ff <= reqSync1_ff;
            reqSeen_ff <= reqSync2_ff;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (reqEdge) begin
                    nxt_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            cmdRw_ff <= '0;
            cmdCode_ff <= '0;
            cmdRail_ff <= '0;
            cmdCrcOk_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_IDLE && reqEdge) begin
                cmdRw_ff <= lnkRw_ff;
                cmdCode_ff <= lnkCmd_ff;
                cmdRail_ff <= lnkRail_ff;
                cmdCrcOk_ff <= lnkCrcOk_ff;
            end
        end
    end

    // per rail telemetry and status
    logic signed [NRAIL-1:0][DATA_W-1:0] smoothCurrent;
    logic [NRAIL-1:0] targetReached;
    logic [NRAIL-1:0] overheatWarn;
    logic [NRAIL-1:0][DATA_W-1:0] statusWord;
    logic [NRAIL-1:0][1:0] statusFlags_ff;
    logic [NRAIL-1:0] alertPend_ff;
    logic [NRAIL-1:0] nxt_alertPend;
    logic [NRAIL-1:0][DATA_W-1:0] target_ff;
    logic [NRAIL-1:0] railHit;
    logic [NRAIL-1:0] statusReadHit;
    logic busControlPrev_ff;
    logic controlRise;
    logic execReload;
    logic execStatusRead;
    logic [RIDX_W-1:0] railIdx;

    assign controlRise = busControl && !busControlPrev_ff;

    for (genvar r = 0; r < NRAIL; r++) begin : gRail
        logic signed [DATA_W:0] voutDiff;
        logic [DATA_W:0] voutDist;
        logic [NSENSE-1:0] senseOver;

        acr_current_filter #(
            .WIDTH(DATA_W),
            .FRAC(8)
        ) uFilter (
            .clk(clk),
            .sys_rst(sys_rst),
            .sampleValid(currentSampleValid[r]),
            .sampleIn(currentSample[r]),
            .smoothShift(smoothShift),
            .smoothOut(smoothCurrent[r])
        );

        assign voutDiff = $signed({voutReading[r][DATA_W-1], voutReading[r]})
            - $signed({target_ff[r][DATA_W-1], target_ff[r]});
        assign voutDist = voutDiff[DATA_W] ? (DATA_W+1)'(-voutDiff) : voutDiff;
        assign targetReached[r] = voutDist <= {1'b0, TARGET_TOL};

        for (genvar s = 0; s < NSENSE; s++) begin : gSense
            assign senseOver[s] = $signed(sensorTemp[s]) > $signed(otWarnLimit[r]);
        end
        assign overheatWarn[r] = |senseOver;

        always_comb begin
            statusWord[r] = STATUS_RESET;
            statusWord[r][STAT_TARGET_BIT] = statusFlags_ff[r][1];
            statusWord[r][STAT_OVERHEAT_BIT] = statusFlags_ff[r][0];
        end

        assign railHit[r] = (cmdRail_ff == RAIL_BROADCAST) || (cmdRail_ff == RAIL_W'(r));
        assign statusReadHit[r] = execStatusRead && (railIdx == RIDX_W'(r));
        // a fresh rise in the read cycle keeps the alert pending
        assign nxt_alertPend[r] = (|({targetReached[r], overheatWarn[r]} & ~statusFlags_ff[r]))
            || (alertPend_ff[r] && !statusReadHit[r]);

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                statusFlags_ff[r] <= '0;
                alertPend_ff[r] <= 1'b0;
                target_ff[r] <= TARGET_RELOAD_DEFAULT;
            end else begin
                statusFlags_ff[r] <= {targetReached[r], overheatWarn[r]};
                alertPend_ff[r] <= nxt_alertPend[r];
                if (controlRise || (execReload && railHit[r])) begin
                    target_ff[r] <= voutCommand[r];
                end
            end
        end
    end

    // command decode
    logic railValid;
    logic isRead;
    logic isWrite;
    logic cmdKnown;
    logic cmdWritable;
    logic [ACK_W-1:0] ackCode;
    logic [DATA_W-1:0] readWord;
    logic [RESP_STAT_W-1:0] statusResp;
    logic selAlert;
    logic inExec;

    assign inExec = state_ff == ST_EXEC;
    assign railValid = (cmdRail_ff < RAIL_W'(NRAIL)) || (cmdRail_ff == RAIL_BROADCAST);
    // a broadcast read answers with rail 0's values
    assign railIdx = (cmdRail_ff == RAIL_BROADCAST) ? '0 : cmdRail_ff[RIDX_W-1:0];
    assign isRead = cmdRw_ff == RW_READ;
    assign isWrite = cmdRw_ff == RW_WRITE;
    assign cmdKnown = (cmdCode_ff == CMD_RAIL_CURRENT) || (cmdCode_ff == CMD_STAGE_TEMP)
        || (cmdCode_ff == CMD_TARGET_RELOAD) || (cmdCode_ff == CMD_STATUS) || (cmdCode_ff == CMD_VERSION);
    // reload is the only write; its data field is ignored, zeros expected
    assign cmdWritable = cmdCode_ff == CMD_TARGET_RELOAD;

    assign ackCode = !cmdCrcOk_ff ? ACK_BAD_CRC
        : (!railValid || !cmdKnown || !(isRead || isWrite) || (isWrite && !cmdWritable)) ? ACK_INVALID
        : (isWrite && !busControl) ? ACK_NO_ACTION
        : ACK_DONE;

    assign execReload = inExec && isWrite && (ackCode == ACK_DONE);
    assign execStatusRead = inExec && isRead && (cmdCode_ff == CMD_STATUS) && (ackCode == ACK_DONE);

    assign readWord = !isRead ? '0
        : (cmdCode_ff == CMD_RAIL_CURRENT) ? smoothCurrent[railIdx]
        : (cmdCode_ff == CMD_STAGE_TEMP) ? readTemperature1[railIdx]
        : (cmdCode_ff == CMD_STATUS) ? statusWord[railIdx]
        : (cmdCode_ff == CMD_VERSION) ? SPEC_VERSION_CODE
        : TARGET_RELOAD_DEFAULT;

    assign selAlert = statusWord[railIdx][STAT_OVERHEAT_BIT];

    always_comb begin
        statusResp = '0;
        statusResp[RESP_TARGET_BIT] = statusWord[railIdx][STAT_TARGET_BIT];
        statusResp[RESP_ALERT_BIT] = selAlert;
        statusResp[RESP_CONTROL_BIT] = busControl;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ackTgl_ff <= 1'b0;
            holdAck_ff <= ACK_DONE;
            holdStatus_ff <= '0;
            holdData_ff <= '0;
            busControlPrev_ff <= 1'b0;
        end else begin
            busControlPrev_ff <= busControl;
            if (inExec) begin
                ackTgl_ff <= ~ackTgl_ff;
                holdAck_ff <= ackCode;
                holdStatus_ff <= statusResp;
                holdData_ff <= (ackCode == ACK_DONE) ? readWord : '0;
            end
        end
    end

    // alert drive of the open-drain slave data line
    logic lineOe_ff;
    logic lineOut_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lineOe_ff <= 1'b0;
            lineOut_ff <= 1'b0;
        end else begin
            lineOe_ff <= |nxt_alertPend;
            lineOut_ff <= 1'b0;
        end
    end

    assign slaveDataLineOe = lineOe_ff;
    assign slaveDataLineOut = lineOut_ff;
    assign targetVoltage = target_ff;

endmodule : acr_command_registers

//--- tb/acr_checker.sv
// concurrent checks on the command register block ports
// assumes it is bound into every instance of the block
`timescale 1ns/1ps
module acr_checker
    import acr_pkg::*;
#(
    parameter int NRAIL = 2
) (
    // clocks and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic linkRst,
    // link side
    input wire logic frameValid,
    input wire logic linkBusy,
    input wire logic respValid,
    input wire logic [ACK_W-1:0] respAck,
    input wire logic [RESP_STAT_W-1:0] respStatus,
    input wire logic [DATA_W-1:0] respData,
    // system side
    input wire logic slaveDataLineOut,
    input wire logic slaveDataLineOe,
    input wire logic busControl,
    input wire logic [NRAIL-1:0][DATA_W-1:0] targetVoltage
);
    chk_busy_after_take: assert property (@(posedge linkClk) disable iff (linkRst)
        frameValid && !linkBusy |=> linkBusy) else $error("busy missing after frame");
    chk_answer_in_time: assert property (@(posedge linkClk) disable iff (linkRst)
        frameValid && !linkBusy |-> ##[4:12] respValid) else $error("answer late");
    chk_answer_pulse: assert property (@(posedge linkClk) disable iff (linkRst)
        respValid |=> !respValid) else $error("answer longer than one cycle");
    chk_busy_ends_answer: assert property (@(posedge linkClk) disable iff (linkRst)
        $fell(linkBusy) |-> respValid) else $error("busy fell without answer");
    chk_answer_stands: assert property (@(posedge linkClk) disable iff (linkRst)
        !respValid |-> $stable(respAck) && $stable(respData) && $stable(respStatus))
        else $error("answer changed between answers");
    chk_refused_no_data: assert property (@(posedge linkClk) disable iff (linkRst)
        respValid && respAck != ACK_DONE |-> respData == 16'h0000) else $error("data on refused frame");
    chk_unused_status: assert property (@(posedge linkClk) disable iff (linkRst)
        respValid |-> respStatus[1:0] == 2'h0) else $error("unused status bits set");
    chk_line_pulls_low: assert property (@(posedge clk) disable iff (sys_rst)
        slaveDataLineOe |-> !slaveDataLineOut) else $error("alert drives line high");
    chk_target_frozen: assert property (@(posedge clk) disable iff (sys_rst)
        !busControl && !$past(busControl) |-> $stable(targetVoltage)) else $error("target moved off control");
    cover property (@(posedge linkClk) respValid && respAck == ACK_DONE);
    cover property (@(posedge linkClk) respValid && respAck == ACK_INVALID);
    cover property (@(posedge clk) $rose(slaveDataLineOe));
endmodule : acr_checker

bind acr_command_registers acr_checker #(.NRAIL(NRAIL)) acr_checker_inst (.clk(clk), .sys_rst(sys_rst),
    .linkClk(linkClk), .linkRst(linkRst), .frameValid(frameValid), .linkBusy(linkBusy),
    .respValid(respValid), .respAck(respAck), .respStatus(respStatus), .respData(respData),
    .slaveDataLineOut(slaveDataLineOut), .slaveDataLineOe(slaveDataLineOe),
    .busControl(busControl), .targetVoltage(targetVoltage));

//--- tb/acr_bus_master.sv
// bus master model: sends decoded frames and collects the answers
// assumes one outstanding frame and frames launched on the falling link edge
`timescale 1ns/1ps
module acr_bus_master
    import acr_pkg::*;
(
    // link clock
    input wire logic linkClk,
    // frame to the slave
    output logic frameValid,
    output logic [RW_W-1:0] frameRw,
    output logic [CMD_W-1:0] frameCmd,
    output logic [RAIL_W-1:0] frameRail,
    output logic [DATA_W-1:0] frameData,
    output logic frameCrcOk,
    // answer from the slave
    input wire logic respValid,
    input wire logic [ACK_W-1:0] respAck,
    input wire logic [RESP_STAT_W-1:0] respStatus,
    input wire logic [DATA_W-1:0] respData
);
    logic [ACK_W-1:0] gotAck;
    logic [RESP_STAT_W-1:0] gotStatus;
    logic [DATA_W-1:0] gotData;
    int idleGap = 0;

    initial begin
        frameValid = 1'b0;
        {frameRw, frameCmd, frameRail, frameData, frameCrcOk} = '0;
    end

    task automatic xfer(input logic [RW_W-1:0] rw, input logic [CMD_W-1:0] cmd,
            input logic [RAIL_W-1:0] rail, input logic [DATA_W-1:0] data, input logic crcOk);
        int n;
        repeat (idleGap + 1) @(negedge linkClk);
        frameValid = 1'b1;
        {frameRw, frameCmd, frameRail, frameData, frameCrcOk} = {rw, cmd, rail, data, crcOk};
        @(negedge linkClk);
        frameValid = 1'b0;
        // released fields must not keep their last value
        {frameRw, frameCmd, frameRail, frameData, frameCrcOk} = ~{rw, cmd, rail, data, crcOk};
        gotAck = 'x;
        gotStatus = 'x;
        gotData = 'x;
        n = 0;
        while (respValid !== 1'b1 && n < 40) begin
            @(negedge linkClk);
            n++;
        end
        if (respValid === 1'b1) begin
            {gotAck, gotStatus, gotData} = {respAck, respStatus, respData};
        end
    endtask : xfer
endmodule : acr_bus_master

//--- tb/tb_top.sv
// self-checking bench for the command register block
// assumes the bus master model and the bound checker
`timescale 1ns/1ps
module tb_top
    import acr_pkg::*;
;
    logic clk, sys_rst, linkClk, linkRst, busControl;
    logic frameValid, frameCrcOk, linkBusy, respValid, slaveDataLineOut, slaveDataLineOe;
    logic [RW_W-1:0] frameRw;
    logic [CMD_W-1:0] frameCmd;
    logic [RAIL_W-1:0] frameRail;
    logic [DATA_W-1:0] frameData, respData;
    logic [ACK_W-1:0] respAck;
    logic [RESP_STAT_W-1:0] respStatus;
    logic [1:0] currentSampleValid;
    logic [FILT_SHIFT_W-1:0] smoothShift;
    logic [1:0][DATA_W-1:0] currentSample, readTemperature1, otWarnLimit, voutCommand;
    logic [1:0][DATA_W-1:0] voutReading, targetVoltage;
    logic [2:0][DATA_W-1:0] sensorTemp;
    wire logic lineLevel = slaveDataLineOe ? slaveDataLineOut : 1'b1;
    int num_errors = 0;
    int compares = 0;

    acr_command_registers acr_command_registers_inst (.clk(clk), .sys_rst(sys_rst), .linkClk(linkClk),
        .linkRst(linkRst), .frameValid(frameValid), .frameRw(frameRw), .frameCmd(frameCmd),
        .frameRail(frameRail), .frameData(frameData), .frameCrcOk(frameCrcOk), .linkBusy(linkBusy),
        .respValid(respValid), .respAck(respAck), .respStatus(respStatus), .respData(respData),
        .slaveDataLineIn(lineLevel), .slaveDataLineOut(slaveDataLineOut), .slaveDataLineOe(slaveDataLineOe),
        .busControl(busControl), .currentSampleValid(currentSampleValid), .currentSample(currentSample),
        .smoothShift(smoothShift), .readTemperature1(readTemperature1), .sensorTemp(sensorTemp),
        .otWarnLimit(otWarnLimit), .voutCommand(voutCommand), .voutReading(voutReading),
        .targetVoltage(targetVoltage));

    acr_bus_master acr_bus_master_inst (.linkClk(linkClk), .frameValid(frameValid), .frameRw(frameRw),
        .frameCmd(frameCmd), .frameRail(frameRail), .frameData(frameData), .frameCrcOk(frameCrcOk),
        .respValid(respValid), .respAck(respAck), .respStatus(respStatus), .respData(respData));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        linkClk = 1'b0;
        #3.3;
        forever #6 linkClk = ~linkClk;
    end

    task automatic eq(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : eq

    task automatic xf(input logic [1:0] rw, input logic [3:0] cmd, input logic [3:0] rail,
            input logic [15:0] data, input logic crc, input logic [1:0] ea, input logic [15:0] ed);
        acr_bus_master_inst.xfer(rw, cmd, rail, data, crc);
        eq(16'(acr_bus_master_inst.gotAck), 16'(ea), "ack");
        eq(acr_bus_master_inst.gotData, ed, "data");
    endtask : xf

    task automatic rd(input logic [3:0] cmd, input logic [3:0] rail, input logic [15:0] ed);
        xf(RW_READ, cmd, rail, 16'hFFFF, 1'b1, ACK_DONE, ed);
    endtask : rd

    task automatic stat(input logic [3:0] rail, input logic [15:0] ed, input logic [4:0] es);
        rd(CMD_STATUS, rail, ed);
        eq(16'(acr_bus_master_inst.gotStatus), 16'(es), "status field");
    endtask : stat

    task automatic sample(input int r, input logic [15:0] v);
        @(negedge clk);
        currentSample[r] = v;
        currentSampleValid[r] = 1'b1;
        @(negedge clk);
        currentSampleValid[r] = 1'b0;
        repeat (3) @(negedge clk);
    endtask : sample

    task automatic t_version();
        rd(CMD_VERSION, 4'h0, SPEC_VERSION_CODE);
        rd(CMD_VERSION, 4'h1, SPEC_VERSION_CODE);
        rd(CMD_VERSION, RAIL_BROADCAST, SPEC_VERSION_CODE);
        xf(RW_WRITE, CMD_VERSION, 4'h0, 16'h0000, 1'b1, ACK_INVALID, 16'h0000);
        xf(RW_WRITE, CMD_STATUS, 4'h0, 16'h0000, 1'b1, ACK_INVALID, 16'h0000);
    endtask : t_version

    task automatic t_temp();
        @(negedge clk);
        readTemperature1[0] = 16'hFF38;
        readTemperature1[1] = 16'h01F4;
        acr_bus_master_inst.idleGap = 3;
        rd(CMD_STAGE_TEMP, 4'h0, 16'hFF38);
        rd(CMD_STAGE_TEMP, 4'h1, 16'h01F4);
        rd(CMD_STAGE_TEMP, RAIL_BROADCAST, 16'hFF38);
        acr_bus_master_inst.idleGap = 0;
    endtask : t_temp

    task automatic t_current();
        sample(0, 16'hFFF6);
        sample(1, 16'h0100);
        rd(CMD_RAIL_CURRENT, 4'h0, 16'hFFF6);
        rd(CMD_RAIL_CURRENT, 4'h1, 16'h0100);
        @(negedge clk);
        smoothShift = 4'h1;
        sample(1, 16'h0300);
        rd(CMD_RAIL_CURRENT, 4'h1, 16'h0200);
        rd(CMD_RAIL_CURRENT, 4'h0, 16'hFFF6);
    endtask : t_current

    task automatic t_reload();
        @(negedge clk);
        voutCommand[0] = 16'h02EE;
        voutCommand[1] = 16'h0384;
        xf(RW_WRITE, CMD_TARGET_RELOAD, 4'h0, 16'h0000, 1'b1, ACK_NO_ACTION, 16'h0000);
        repeat (4) @(negedge clk);
        eq(targetVoltage[0], 16'h0000, "target kept");
        busControl = 1'b1;
        repeat (4) @(negedge clk);
        eq(targetVoltage[1], 16'h0384, "target on control");
        voutCommand[0] = 16'h0320;
        xf(RW_WRITE, CMD_TARGET_RELOAD, 4'h0, 16'h0000, 1'b0, ACK_BAD_CRC, 16'h0000);
        xf(RW_WRITE, CMD_RAIL_CURRENT, 4'h0, 16'h0000, 1'b1, ACK_INVALID, 16'h0000);
        xf(RW_WRITE, 4'h5, 4'h0, 16'h0000, 1'b1, ACK_INVALID, 16'h0000);
        xf(2'h1, CMD_VERSION, 4'h0, 16'h0000, 1'b1, ACK_INVALID, 16'h0000);
        xf(RW_READ, CMD_VERSION, 4'h5, 16'hFFFF, 1'b1, ACK_INVALID, 16'h0000);
        eq(targetVoltage[0], 16'h02EE, "target after refusals");
        xf(RW_WRITE, CMD_TARGET_RELOAD, 4'h0, 16'h0000, 1'b1, ACK_DONE, 16'h0000);
        repeat (3) @(negedge clk);
        eq(targetVoltage[0], 16'h0320, "rail reload");
        eq(targetVoltage[1], 16'h0384, "other rail kept");
        voutCommand = {16'h0400, 16'h0300};
        xf(RW_WRITE, CMD_TARGET_RELOAD, RAIL_BROADCAST, 16'h0000, 1'b1, ACK_DONE, 16'h0000);
        repeat (3) @(negedge clk);
        eq(targetVoltage[1], 16'h0400, "broadcast reload 1");
        eq(targetVoltage[0], 16'h0300, "broadcast reload 0");
    endtask : t_reload

    task automatic t_status();
        @(negedge clk);
        voutReading[0] = 16'h0300;
        repeat (4) @(negedge clk);
        stat(4'h0, 16'h8000, 5'h14);
        stat(4'h1, 16'h0000, 5'h04);
        repeat (4) @(negedge clk);
        eq(16'(lineLevel), 16'h0001, "line released");
        otWarnLimit[1] = 16'h0100;
        sensorTemp[2] = 16'h0200;
        repeat (5) @(negedge clk);
        eq(16'(lineLevel), 16'h0000, "line alert");
        stat(4'h1, 16'h1000, 5'h0C);
        stat(4'h0, 16'h8000, 5'h14);
        repeat (4) @(negedge clk);
        eq(16'(lineLevel), 16'h0001, "line released after read");
    endtask : t_status

    task automatic results();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        {sys_rst, linkRst, busControl, currentSampleValid, smoothShift} = {2'b11, 7'h00};
        {currentSample, readTemperature1, voutCommand, voutReading} = '0;
        sensorTemp = '0;
        otWarnLimit = {16'h7FFF, 16'h7FFF};
        repeat (16) @(negedge clk);
        eq(targetVoltage[0], 16'h0000, "target reset 0");
        eq(targetVoltage[1], 16'h0000, "target reset 1");
        eq(16'({respValid, linkBusy}), 16'h0000, "link reset");
        sys_rst = 1'b0;
        @(negedge linkClk);
        linkRst = 1'b0;
        repeat (4) @(negedge clk);
        t_version();
        t_temp();
        t_current();
        t_reload();
        t_status();
        results();
    end

    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule : tb_top
